// ---- logic/sfpe_pkg.sv ----
// shared constants and types of the serial flash program/erase sequencer
package sfpe_pkg;
	// ==========================================================
	// clock and self-timed intervals
	localparam int unsigned CLK_MHZ        = 25;
	localparam int unsigned PP_TIME_US     = 600;
	localparam int unsigned SE_TIME_US     = 50000;
	localparam int unsigned RST_TIME_US    = 30;
	localparam int unsigned PP_CYCLES_DEF  = PP_TIME_US * CLK_MHZ;
	localparam int unsigned SE_CYCLES_DEF  = SE_TIME_US * CLK_MHZ;
	localparam int unsigned RST_CYCLES     = RST_TIME_US * CLK_MHZ;
	localparam int unsigned TMR_W          = 21;

	// ==========================================================
	// instruction codes
	localparam logic [7:0] OPC_WREN        = 8'h06;
	localparam logic [7:0] OPC_WRDI        = 8'h04;
	localparam logic [7:0] OPC_RDSR        = 8'h05;
	localparam logic [7:0] OPC_SR_ERASE    = 8'h44;
	localparam logic [7:0] OPC_SR_PROG     = 8'h42;
	localparam logic [7:0] OPC_RST_EN      = 8'h66;
	localparam logic [7:0] OPC_RST         = 8'h99;
	localparam logic [7:0] OPC_PP          = 8'h02;
	localparam logic [7:0] OPC_QPP         = 8'h32;

	// ==========================================================
	// address layout, status byte, protection geometry
	localparam int unsigned ADDR_W         = 24;
	localparam int unsigned PAGE_BYTES     = 256;
	localparam logic [7:0]  SR_UPPER       = 8'h00;
	localparam logic [3:0]  SR_MID         = 4'h0;
	localparam logic [3:0]  SR_FIRST       = 4'h1;
	localparam logic [3:0]  SR_LAST        = 4'h3;
	localparam int unsigned ST_WIP_BIT     = 0;
	localparam int unsigned ST_WEL_BIT     = 1;
	localparam logic [14:0] ARRAY_PAGES    = 15'h4000;
	localparam logic [14:0] PROT_BLK_PAGES = 15'h0100;
	localparam logic [14:0] PROT_SEC_PAGES = 15'h0010;

	// ==========================================================
	// synchronised pin vector and program word
	localparam int unsigned PIN_W          = 6;
	localparam int unsigned PIN_CS         = 5;
	localparam int unsigned PIN_SCLK       = 4;
	localparam logic [5:0]  PIN_RST        = 6'h20;
	localparam int unsigned PW_W           = 33;
	localparam int unsigned FIFO_DEPTH     = 2;

	typedef enum logic [5:0] {
		PH_OPC  = 6'h01,
		PH_ADDR = 6'h02,
		PH_DATA = 6'h04,
		PH_STAT = 6'h08,
		PH_DONE = 6'h10,
		PH_IGN  = 6'h20
	} sfpe_phase_e;

	typedef enum logic [3:0] {
		OP_IDLE  = 4'h1,
		OP_PROG  = 4'h2,
		OP_ERASE = 4'h4,
		OP_RESET = 4'h8
	} sfpe_op_e;
endpackage : sfpe_pkg

// ---- logic/sfpe_stream_if.sv ----
// valid/ready word stream between sequencer and buffer
`timescale 1ns/100ps
interface sfpe_stream_if #(
	parameter int unsigned W = 33
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sfpe_stream_if

// ---- logic/sfpe_pair_fifo.sv ----
// small shift-register buffer; head entry and valid come straight from flops
`timescale 1ns/100ps
module sfpe_pair_fifo #(
	parameter int unsigned WIDTH = 33,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic   clk_sys, // system clock
	input  wire logic   rst_b,   // synchronous reset, active low
	sfpe_stream_if.snk  in_if,   // filling side
	sfpe_stream_if.src  out_if   // draining side
);
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] ent_ff [DEPTH];
	logic [WIDTH-1:0] nxt_ent_ff [DEPTH];
	logic [CW-1:0]    cnt_ff;
	logic [CW-1:0]    nxt_cnt_ff;
	logic             valid_ff;
	logic             nxt_valid_ff;
	logic             push;
	logic             pop;
	logic [CW-1:0]    wpos;

	assign in_if.ready  = (cnt_ff != CW'(DEPTH));
	assign out_if.valid = valid_ff;
	assign out_if.data  = ent_ff[0];

	// ==========================================================
	// next state
	always_comb begin
		push = in_if.valid & in_if.ready;
		pop  = valid_ff & out_if.ready;
		wpos = cnt_ff - CW'(pop);
		for (int i = 0; i < DEPTH; i++) begin
			if (pop && (i + 1 < DEPTH))
				nxt_ent_ff[i] = ent_ff[i + 1];
			else
				nxt_ent_ff[i] = ent_ff[i];
			if (push && (CW'(i) == wpos))
				nxt_ent_ff[i] = in_if.data;
		end
		nxt_cnt_ff   = cnt_ff + CW'(push) - CW'(pop);
		nxt_valid_ff = (nxt_cnt_ff != '0);
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			cnt_ff   <= '0;
			valid_ff <= 1'b0;
			for (int i = 0; i < DEPTH; i++)
				ent_ff[i] <= '0;
		end else begin
			cnt_ff   <= nxt_cnt_ff;
			valid_ff <= nxt_valid_ff;
			ent_ff   <= nxt_ent_ff;
		end
	end
endmodule : sfpe_pair_fifo

// ---- logic/sfpe_flash_seq.sv ----
// serial flash program/erase/security/reset instruction sequencer
// ==========================================================
`timescale 1ns/100ps
module sfpe_flash_seq #(
	parameter int unsigned PP_CYCLES = sfpe_pkg::PP_CYCLES_DEF, // page program cycles
	parameter int unsigned SE_CYCLES = sfpe_pkg::SE_CYCLES_DEF  // sector erase cycles
) (
	input  wire logic                        clk_sys,                   // 25 MHz clock
	input  wire logic                        rst_b,                     // sync reset, low
	input  wire logic                        cs_n_pin,                  // chip select, low
	input  wire logic                        sclk_pin,                  // serial clock
	input  wire logic [3:0]                  io_in,                     // io lines in
	output logic      [3:0]                  io_out,                    // io lines out
	output logic      [3:0]                  io_oe,                     // io drive enable
	input  wire logic                        security_lock_bit,         // erase lock
	input  wire logic [2:0]                  per_register_lock_bits,    // program locks
	input  wire logic                        quad_enable_bit,           // quad allowed
	input  wire logic [4:0]                  block_protect_bits,        // array protection
	output logic                             write_in_progress_flag,    // busy
	output logic                             write_enable_latch,        // write enabled
	output logic                             suspend_status_flag,       // suspended
	output logic      [7:0]                  continuous_read_mode_bits, // read mode
	output logic      [2:0]                  wrap_setting_bits,         // wrap setting
	output logic                             reset_busy,                // reset interval
	output logic                             soft_reset_pulse,          // reset accepted
	output logic                             secreg_erase_pulse,        // erase started
	output logic                             prog_valid,                // program word valid
	input  wire logic                        prog_ready,                // program word taken
	output logic                             prog_is_secreg,            // target security
	output logic      [sfpe_pkg::ADDR_W-1:0] prog_addr,                 // byte address
	output logic      [7:0]                  prog_data                  // byte value
);
	import sfpe_pkg::*;

	sfpe_stream_if #(.W(PW_W)) push_if ();
	sfpe_stream_if #(.W(PW_W)) pop_if ();

	sfpe_pair_fifo #(.WIDTH(PW_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.in_if   (push_if),
		.out_if  (pop_if)
	);

	assign prog_valid                           = pop_if.valid;
	assign pop_if.ready                         = prog_ready;
	assign {prog_is_secreg, prog_addr, prog_data} = pop_if.data;

	// true when the page falls in the region the protect bits cover
	function automatic logic page_protected(input logic [4:0] bp, input logic [15:0] page);
		logic [14:0] span;
		logic [14:0] pg;
		span = '0;
		pg   = {1'b0, page[13:0]};
		if (bp[2:0] == 3'h0)
			return 1'b0;
		if (bp[2:0] == 3'h7)
			return 1'b1;
		span = (bp[4] ? PROT_SEC_PAGES : PROT_BLK_PAGES) << (bp[2:0] - 3'h1);
		if (bp[3])
			return pg < span;
		return pg >= (ARRAY_PAGES - span);
	endfunction : page_protected

	// ==========================================================
	// pin synchroniser
	logic [PIN_W-1:0] pin_s1_ff;
	logic [PIN_W-1:0] pin_s2_ff;
	logic [PIN_W-1:0] pin_d_ff;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pin_s1_ff <= PIN_RST;
			pin_s2_ff <= PIN_RST;
			pin_d_ff  <= PIN_RST;
		end else begin
			pin_s1_ff <= {cs_n_pin, sclk_pin, io_in};
			pin_s2_ff <= pin_s1_ff;
			pin_d_ff  <= pin_s2_ff;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	assign cs_fall  = pin_d_ff[PIN_CS] & ~pin_s2_ff[PIN_CS];
	assign cs_rise  = ~pin_d_ff[PIN_CS] & pin_s2_ff[PIN_CS];
	assign sck_rise = ~pin_s2_ff[PIN_CS] & ~pin_d_ff[PIN_SCLK] & pin_s2_ff[PIN_SCLK];
	assign sck_fall = ~pin_s2_ff[PIN_CS] & pin_d_ff[PIN_SCLK] & ~pin_s2_ff[PIN_SCLK];

	// ==========================================================
	// sequencer state
	sfpe_phase_e       ph_ff, nxt_ph_ff;
	sfpe_op_e          op_ff, nxt_op_ff;
	logic [4:0]        cnt_ff, nxt_cnt_ff;
	logic [23:0]       sh_ff, nxt_sh_ff;
	logic [7:0]        opc_ff, nxt_opc_ff;
	logic [23:0]       addr_ff, nxt_addr_ff;
	logic [7:0]        ptr_ff, nxt_ptr_ff;
	logic              got_ff, nxt_got_ff;
	logic              armed_ff, nxt_armed_ff;
	logic              sec_ff, nxt_sec_ff;
	logic [TMR_W-1:0]  tmr_ff, nxt_tmr_ff;
	logic [8:0]        didx_ff, nxt_didx_ff;
	logic [2:0]        sidx_ff, nxt_sidx_ff;
	logic [7:0]        page_ff [PAGE_BYTES];
	logic [7:0]        nxt_page_ff [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_ff, nxt_mask_ff;
	logic              wip_ff, nxt_wip_ff;
	logic              wel_ff, nxt_wel_ff;
	logic              sus_ff, nxt_sus_ff;
	logic [7:0]        crm_ff, nxt_crm_ff;
	logic [2:0]        wrap_ff, nxt_wrap_ff;
	logic              rstp_ff, nxt_rstp_ff;
	logic              erp_ff, nxt_erp_ff;
	logic [3:0]        ioo_ff, nxt_ioo_ff;
	logic [3:0]        ioe_ff, nxt_ioe_ff;

	logic       io0;
	logic       quad;
	logic       done1;
	logic       pclean;
	logic [7:0] byte_in;
	logic       byte_done;
	logic [1:0] sr_sel;
	logic       sr_ok;
	logic [7:0] status;
	logic       drain;

	always_comb begin
		io0        = pin_s2_ff[0];
		quad       = (opc_ff == OPC_QPP);
		done1      = (ph_ff == PH_DONE);
		pclean     = (ph_ff == PH_DATA) && (cnt_ff == 5'h00) && got_ff;
		byte_in    = quad ? {sh_ff[3:0], pin_s2_ff[3:0]} : {sh_ff[6:0], io0};
		byte_done  = quad ? (cnt_ff == 5'h01) : (cnt_ff == 5'h07);
		sr_sel     = addr_ff[13:12];
		sr_ok      = (addr_ff[23:16] == SR_UPPER) && (addr_ff[11:8] == SR_MID)
		             && (addr_ff[15:12] >= SR_FIRST) && (addr_ff[15:12] <= SR_LAST)
		             && !per_register_lock_bits[sr_sel - 2'h1];
		status     = {1'b0, block_protect_bits, wel_ff, wip_ff};
		drain      = (op_ff == OP_PROG) && !didx_ff[8];
		push_if.valid = drain && mask_ff[didx_ff[7:0]];
		push_if.data  = {sec_ff, addr_ff[23:8], didx_ff[7:0], page_ff[didx_ff[7:0]]};

		nxt_ph_ff    = ph_ff;
		nxt_op_ff    = op_ff;
		nxt_cnt_ff   = cnt_ff;
		nxt_sh_ff    = sh_ff;
		nxt_opc_ff   = opc_ff;
		nxt_addr_ff  = addr_ff;
		nxt_ptr_ff   = ptr_ff;
		nxt_got_ff   = got_ff;
		nxt_armed_ff = armed_ff;
		nxt_sec_ff   = sec_ff;
		nxt_tmr_ff   = tmr_ff;
		nxt_didx_ff  = didx_ff;
		nxt_sidx_ff  = sidx_ff;
		nxt_page_ff  = page_ff;
		nxt_mask_ff  = mask_ff;
		nxt_wip_ff   = wip_ff;
		nxt_wel_ff   = wel_ff;
		nxt_sus_ff   = sus_ff;
		nxt_crm_ff   = crm_ff;
		nxt_wrap_ff  = wrap_ff;
		nxt_rstp_ff  = 1'b0;
		nxt_erp_ff   = 1'b0;
		nxt_ioo_ff   = ioo_ff;
		nxt_ioe_ff   = ioe_ff;

		// self-timed work; program words drain while the timer runs
		if (drain && (!mask_ff[didx_ff[7:0]] || push_if.ready))
			nxt_didx_ff = didx_ff + 9'h001;
		if (op_ff != OP_IDLE) begin
			if (tmr_ff != '0)
				nxt_tmr_ff = tmr_ff - TMR_W'(1);
			else if (!drain) begin
				nxt_op_ff  = OP_IDLE;
				nxt_wip_ff = 1'b0;
			end
		end

		// ==========================================================
		// serial frame
		if (cs_fall) begin
			nxt_ph_ff  = PH_OPC;
			nxt_cnt_ff = '0;
			nxt_got_ff = 1'b0;
			if (op_ff == OP_IDLE)
				nxt_mask_ff = '0;
		end else if (sck_rise) begin
			unique case (ph_ff)
				PH_OPC: begin
					nxt_sh_ff  = {sh_ff[22:0], io0};
					nxt_cnt_ff = cnt_ff + 5'h01;
					if (cnt_ff == 5'h07) begin
						nxt_opc_ff = {sh_ff[6:0], io0};
						nxt_cnt_ff = '0;
						nxt_sidx_ff = '0;
						if (op_ff == OP_RESET)
							nxt_ph_ff = PH_IGN;
						else if (nxt_opc_ff == OPC_RDSR)
							nxt_ph_ff = PH_STAT;
						else if (nxt_opc_ff == OPC_RST_EN || nxt_opc_ff == OPC_RST)
							nxt_ph_ff = PH_DONE;
						else if (op_ff != OP_IDLE)
							nxt_ph_ff = PH_IGN;
						else if (nxt_opc_ff == OPC_PP || nxt_opc_ff == OPC_QPP
						         || nxt_opc_ff == OPC_SR_PROG)
							nxt_ph_ff = PH_ADDR;
						else
							nxt_ph_ff = PH_DONE;
					end
				end
				PH_ADDR: begin
					nxt_sh_ff  = {sh_ff[22:0], io0};
					nxt_cnt_ff = cnt_ff + 5'h01;
					if (cnt_ff == 5'h17) begin
						nxt_addr_ff = {sh_ff[22:0], io0};
						nxt_ptr_ff  = nxt_addr_ff[7:0];
						nxt_cnt_ff  = '0;
						nxt_ph_ff   = PH_DATA;
					end
				end
				PH_DATA: begin
					nxt_sh_ff  = quad ? {sh_ff[19:0], pin_s2_ff[3:0]} : {sh_ff[22:0], io0};
					nxt_cnt_ff = cnt_ff + 5'h01;
					if (byte_done) begin
						nxt_page_ff[ptr_ff] = byte_in;
						nxt_mask_ff[ptr_ff] = 1'b1;
						nxt_ptr_ff          = ptr_ff + 8'h01;
						nxt_got_ff          = 1'b1;
						nxt_cnt_ff          = '0;
					end
				end
				PH_DONE: nxt_ph_ff = PH_IGN;
				PH_STAT: ;
				PH_IGN:  ;
			endcase
		end else if (sck_fall && ph_ff == PH_STAT) begin
			nxt_ioo_ff[1] = status[3'h7 - sidx_ff];
			nxt_ioe_ff[1] = 1'b1;
			nxt_sidx_ff   = sidx_ff + 3'h1;
		end

		// ==========================================================
		// execution on chip select release
		if (cs_rise) begin
			nxt_ph_ff  = PH_IGN;
			nxt_ioe_ff = '0;
			if (op_ff != OP_RESET && ph_ff != PH_OPC) begin
				nxt_armed_ff = done1 && (opc_ff == OPC_RST_EN);
				if (done1 && opc_ff == OPC_RST && armed_ff) begin
					nxt_op_ff    = OP_RESET;
					nxt_tmr_ff   = TMR_W'(RST_CYCLES);
					nxt_wip_ff   = 1'b0;
					nxt_wel_ff   = 1'b0;
					nxt_sus_ff   = 1'b0;
					nxt_crm_ff   = '0;
					nxt_wrap_ff  = '0;
					nxt_rstp_ff  = 1'b1;
					nxt_armed_ff = 1'b0;
				end else if (op_ff == OP_IDLE) begin
					if (done1 && opc_ff == OPC_WREN)
						nxt_wel_ff = 1'b1;
					if (done1 && opc_ff == OPC_WRDI)
						nxt_wel_ff = 1'b0;
					if (done1 && opc_ff == OPC_SR_ERASE && wel_ff
					    && !security_lock_bit) begin
						nxt_op_ff  = OP_ERASE;
						nxt_tmr_ff = TMR_W'(SE_CYCLES);
						nxt_wip_ff = 1'b1;
						nxt_wel_ff = 1'b0;
						nxt_erp_ff = 1'b1;
					end
					if (pclean && wel_ff
					    && ((opc_ff == OPC_SR_PROG && sr_ok)
					     || (opc_ff == OPC_PP && !page_protected(block_protect_bits,
					                                              addr_ff[23:8]))
					     || (opc_ff == OPC_QPP && quad_enable_bit
					         && !page_protected(block_protect_bits, addr_ff[23:8])))) begin
						nxt_op_ff   = OP_PROG;
						nxt_sec_ff  = (opc_ff == OPC_SR_PROG);
						nxt_tmr_ff  = TMR_W'(PP_CYCLES);
						nxt_didx_ff = '0;
						nxt_wip_ff  = 1'b1;
						nxt_wel_ff  = 1'b0;
					end
				end
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ph_ff    <= PH_IGN;
			op_ff    <= OP_IDLE;
			cnt_ff   <= '0;
			sh_ff    <= '0;
			opc_ff   <= '0;
			addr_ff  <= '0;
			ptr_ff   <= '0;
			got_ff   <= 1'b0;
			armed_ff <= 1'b0;
			sec_ff   <= 1'b0;
			tmr_ff   <= '0;
			didx_ff  <= 9'h100;
			sidx_ff  <= '0;
			mask_ff  <= '0;
			wip_ff   <= 1'b0;
			wel_ff   <= 1'b0;
			sus_ff   <= 1'b0;
			crm_ff   <= '0;
			wrap_ff  <= '0;
			rstp_ff  <= 1'b0;
			erp_ff   <= 1'b0;
			ioo_ff   <= '0;
			ioe_ff   <= '0;
			for (int i = 0; i < PAGE_BYTES; i++)
				page_ff[i] <= '0;
		end else begin
			ph_ff    <= nxt_ph_ff;
			op_ff    <= nxt_op_ff;
			cnt_ff   <= nxt_cnt_ff;
			sh_ff    <= nxt_sh_ff;
			opc_ff   <= nxt_opc_ff;
			addr_ff  <= nxt_addr_ff;
			ptr_ff   <= nxt_ptr_ff;
			got_ff   <= nxt_got_ff;
			armed_ff <= nxt_armed_ff;
			sec_ff   <= nxt_sec_ff;
			tmr_ff   <= nxt_tmr_ff;
			didx_ff  <= nxt_didx_ff;
			sidx_ff  <= nxt_sidx_ff;
			mask_ff  <= nxt_mask_ff;
			wip_ff   <= nxt_wip_ff;
			wel_ff   <= nxt_wel_ff;
			sus_ff   <= nxt_sus_ff;
			crm_ff   <= nxt_crm_ff;
			wrap_ff  <= nxt_wrap_ff;
			rstp_ff  <= nxt_rstp_ff;
			erp_ff   <= nxt_erp_ff;
			ioo_ff   <= nxt_ioo_ff;
			ioe_ff   <= nxt_ioe_ff;
			page_ff  <= nxt_page_ff;
		end
	end

	assign io_out                    = ioo_ff;
	assign io_oe                     = ioe_ff;
	assign write_in_progress_flag    = wip_ff;
	assign write_enable_latch        = wel_ff;
	assign suspend_status_flag       = sus_ff;
	assign continuous_read_mode_bits = crm_ff;
	assign wrap_setting_bits         = wrap_ff;
	// op_ff is one-hot, so this bit is the reset state's own flop
	assign reset_busy                = op_ff[3];
	assign soft_reset_pulse          = rstp_ff;
	assign secreg_erase_pulse        = erp_ff;
endmodule : sfpe_flash_seq

// ---- tb/sfpe_flash_seq_sva.sv ----
// assertion checker for the flash program/erase sequencer
`timescale 1ns/100ps
module sfpe_flash_seq_chk
	import sfpe_pkg::*;
#(
	parameter int unsigned PP_CYCLES = 40, // page program cycles
	parameter int unsigned SE_CYCLES = 60  // sector erase cycles
) (
	input wire logic              clk_sys,                // clock
	input wire logic              rst_b,                  // reset, low
	input wire logic              security_lock_bit,      // erase lock
	input wire logic              write_in_progress_flag, // busy
	input wire logic              write_enable_latch,     // write enabled
	input wire logic              reset_busy,             // reset interval
	input wire logic              soft_reset_pulse,       // reset accepted
	input wire logic              secreg_erase_pulse,     // erase started
	input wire logic              prog_valid,             // word valid
	input wire logic              prog_ready,             // word taken
	input wire logic              prog_is_secreg,         // security target
	input wire logic [ADDR_W-1:0] prog_addr,              // byte address
	input wire logic [7:0]        prog_data               // byte value
);
	// ==========================================
	// run lengths of busy and reset spans
	logic [TMR_W-1:0] wip_cnt_ff, nxt_wip_cnt, rb_cnt_ff, nxt_rb_cnt;
	logic             er_ff, nxt_er;
	always_comb begin
		nxt_wip_cnt = (rst_b && write_in_progress_flag) ? wip_cnt_ff + 1'b1 : '0;
		nxt_rb_cnt  = (rst_b && reset_busy) ? rb_cnt_ff + 1'b1 : '0;
		// erase mark survives until its busy span has ended
		nxt_er = rst_b && (secreg_erase_pulse || (er_ff && (write_in_progress_flag
			|| wip_cnt_ff == '0)));
	end
	always_ff @(posedge clk_sys) begin
		wip_cnt_ff <= nxt_wip_cnt;
		rb_cnt_ff  <= nxt_rb_cnt;
		er_ff      <= nxt_er;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ==========================================
	// properties
	wip_clears_wel_a: assert property ($rose(write_in_progress_flag)
		|-> !write_enable_latch) else $error("write latch still set when busy began");
	pp_time_a: assert property ($fell(write_in_progress_flag) && !reset_busy
		&& !soft_reset_pulse |-> wip_cnt_ff >= PP_CYCLES)
		else $error("busy span shorter than program time");
	se_time_a: assert property ($fell(write_in_progress_flag) && er_ff && !reset_busy
		|-> wip_cnt_ff >= SE_CYCLES) else $error("busy span shorter than erase time");
	erase_start_a: assert property (secreg_erase_pulse
		|-> !security_lock_bit ##[0:2] write_in_progress_flag) else $error("bad erase start");
	rst_len_a: assert property ($fell(reset_busy)
		|-> rb_cnt_ff inside {[RST_CYCLES - 1:RST_CYCLES + 1]}) else $error("reset span length");
	rst_clear_a: assert property ($past(reset_busy) && reset_busy
		|-> !write_in_progress_flag && !write_enable_latch) else $error("state kept in reset");
	wel_refuse_a: assert property ($rose(write_enable_latch)
		|-> !$past(reset_busy) && !$past(write_in_progress_flag)) else $error("latch set while busy");
	word_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid
		&& $stable({prog_is_secreg, prog_addr, prog_data})) else $error("word dropped in stall");
	sec_addr_a: assert property (prog_valid && prog_is_secreg
		|-> prog_addr[23:16] == 8'h00 && prog_addr[11:8] == 4'h0
		&& prog_addr[15:12] inside {[1:3]}) else $error("bad secure addr");
endmodule : sfpe_flash_seq_chk

bind sfpe_flash_seq sfpe_flash_seq_chk #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES)) u_chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .security_lock_bit(security_lock_bit),
	.write_in_progress_flag(write_in_progress_flag), .write_enable_latch(write_enable_latch),
	.reset_busy(reset_busy), .soft_reset_pulse(soft_reset_pulse),
	.secreg_erase_pulse(secreg_erase_pulse), .prog_valid(prog_valid), .prog_ready(prog_ready),
	.prog_is_secreg(prog_is_secreg), .prog_addr(prog_addr), .prog_data(prog_data));

// ---- tb/sfpe_spi_host.sv ----
// host controller model driving the flash pins
`timescale 1ns/100ps
module sfpe_spi_host (
	input  wire logic       clk_sys, // system clock
	input  wire logic       so,      // device serial out
	output logic            cs_n,    // chip select, low
	output logic            sclk,    // serial clock, idles low
	output logic      [3:0] io       // host io drive
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io   = 4'h5;
	end
	// ==========================================
	// one bit per 8 clocks; read bit taken before the rising edge
	task automatic clk_bit(input logic [3:0] v, output logic s);
		@(posedge clk_sys);
		io   <= v;
		sclk <= 1'b0;
		repeat (4) @(posedge clk_sys);
		s = so;
		sclk <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask : clk_bit
	// unused lines toggle so a stale level never reads as data
	task automatic send(input logic [31:0] v, input int n);
		logic s;
		for (int i = n - 1; i >= 0; i--)
			clk_bit({~io[3:1], v[i]}, s);
	endtask : send
	task automatic get(output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			clk_bit({~io[3:1], 1'b0}, r[i]);
	endtask : get
	task automatic cs_lo;
		@(posedge clk_sys);
		cs_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : cs_lo
	// frame closes right after the last bit sent, even mid-unit; released lines invert
	task automatic cs_hi;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		sclk <= 1'b0;
		io   <= ~io;
		repeat (6) @(posedge clk_sys);
	endtask : cs_hi
endmodule : sfpe_spi_host

// ---- tb/sfpe_flash_seq_tb.sv ----
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/100ps
module sfpe_flash_seq_tb;
	import sfpe_pkg::*;
	localparam int unsigned PP = 400;
	localparam int unsigned SE = 600;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        cs_n_pin, sclk_pin, prog_ready = 1'b0;
	logic [3:0]  io_in, io_out, io_oe, hio;
	logic        security_lock_bit = 1'b0;
	logic [2:0]  per_register_lock_bits = 3'h0;
	logic        quad_enable_bit = 1'b0;
	logic [4:0]  block_protect_bits = 5'h00;
	logic        write_in_progress_flag, write_enable_latch, suspend_status_flag;
	logic [7:0]  continuous_read_mode_bits, prog_data;
	logic [2:0]  wrap_setting_bits;
	logic        reset_busy, soft_reset_pulse, secreg_erase_pulse, prog_valid, prog_is_secreg;
	logic [23:0] prog_addr;
	logic [32:0] got[$], exp[$];
	int          mismatches = 0, n_compared = 0, n_rst = 0, n_ers = 0, cyc = 0;
	always #20 clk_sys = ~clk_sys;
	assign io_in = {hio[3:2], io_oe[1] ? io_out[1] : hio[1], hio[0]};
	sfpe_spi_host host (.clk_sys(clk_sys), .so(io_in[1]), .cs_n(cs_n_pin), .sclk(sclk_pin),
		.io(hio));
	sfpe_flash_seq #(.PP_CYCLES(PP), .SE_CYCLES(SE)) uut (.*);
	// receiver stalls 8 cycles of every 16 so the buffer fills up
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		prog_ready <= cyc[3];
		if (prog_valid && prog_ready) got.push_back({prog_is_secreg, prog_addr, prog_data});
		if (soft_reset_pulse) n_rst++;
		if (secreg_erase_pulse) n_ers++;
	end
	// ==========================================
	// checking and closing
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic idle;
		int i;
		for (i = 0; i < 9000 && (write_in_progress_flag | prog_valid | reset_busy) !== 1'b0; i++)
			@(posedge clk_sys);
		if (i == 9000) chk(1, 0);
	endtask : idle
	// ==========================================
	// instruction frames
	task automatic cmd(input logic [7:0] op, input int xb = 0);
		host.cs_lo();
		host.send({24'h0, op} << xb, 8 + xb);
		host.cs_hi();
	endtask : cmd
	task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
		input bit w, ok, part = 0);
		logic [7:0] ex [256];
		bit         wr [256];
		logic [7:0] d, s;
		got.delete();
		exp.delete();
		cmd(w ? OPC_WREN : OPC_WRDI);
		host.cs_lo();
		host.send({op, a}, 32);
		for (int i = 0; i < n; i++) begin
			d = 8'(i * 37 + 5);
			ex[(a[7:0] + i) % 256] = d;
			wr[(a[7:0] + i) % 256] = 1'b1;
			if (op == OPC_QPP) begin
				host.clk_bit(d[7:4], s[0]);
				host.clk_bit(d[3:0], s[0]);
			end else
				host.send({24'h0, d}, 8);
		end
		if (part) host.send(32'h5, 4);
		host.cs_hi();
		chk(write_in_progress_flag, ok);
		chk(write_enable_latch, w && !ok);
		host.cs_lo();
		host.send({24'h0, OPC_RDSR}, 8);
		host.get(s);
		host.cs_hi();
		chk(s, {1'b0, block_protect_bits, w && !ok, ok});
		idle();
		for (int k = 0; k < 256; k++)
			if (wr[k] && ok) exp.push_back({op == OPC_SR_PROG, a[23:8], 8'(k), ex[k]});
		chk(33'(got.size()), 33'(exp.size()));
		foreach (exp[j]) chk(got[j], exp[j]);
	endtask : prog
	task automatic erase(input bit w, input int xb, input bit ok);
		int e;
		e = n_ers;
		cmd(w ? OPC_WREN : OPC_WRDI);
		cmd(OPC_SR_ERASE, xb);
		chk(33'(n_ers - e), ok);
		chk({write_in_progress_flag, write_enable_latch}, {ok, w && !ok});
		idle();
	endtask : erase
	// ==========================================
	// test sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk({write_in_progress_flag, write_enable_latch, suspend_status_flag, reset_busy,
			continuous_read_mode_bits, wrap_setting_bits}, '0);
		prog(OPC_PP, 24'h0100FE, 258, 1, 1);
		prog(OPC_PP, 24'h010000, 2, 0, 0);
		prog(OPC_PP, 24'h010010, 2, 1, 0, 1);
		block_protect_bits <= 5'h07;
		prog(OPC_PP, 24'h010000, 1, 1, 0);
		// sector-sized span at the top, then block-sized span at the bottom
		block_protect_bits <= 5'h11;
		prog(OPC_PP, 24'h3FF000, 1, 1, 0);
		block_protect_bits <= 5'h09;
		prog(OPC_PP, 24'h010000, 1, 1, 1);
		block_protect_bits <= 5'h00;
		prog(OPC_QPP, 24'h020010, 3, 1, 0);
		quad_enable_bit <= 1'b1;
		prog(OPC_QPP, 24'h0200FE, 3, 1, 1);
		per_register_lock_bits <= 3'h1;
		prog(OPC_SR_PROG, 24'h002005, 2, 1, 1);
		prog(OPC_SR_PROG, 24'h001000, 1, 1, 0);
		prog(OPC_SR_PROG, 24'h004000, 1, 1, 0);
		erase(0, 0, 0);
		erase(1, 1, 0);
		security_lock_bit <= 1'b1;
		erase(1, 0, 0);
		security_lock_bit <= 1'b0;
		erase(1, 0, 1);
		// reset pair only issued once the device is idle
		chk({write_in_progress_flag, suspend_status_flag}, 0);
		cmd(OPC_WREN);
		cmd(OPC_RST_EN);
		cmd(OPC_RDSR);
		cmd(OPC_RST);
		chk({32'(n_rst), write_enable_latch}, {32'(0), 1'b1});
		cmd(OPC_RST_EN);
		cmd(OPC_RST);
		chk({31'(n_rst), reset_busy, write_enable_latch}, {31'(1), 2'b10});
		cmd(OPC_WREN);
		chk(write_enable_latch, 1'b0);
		idle();
		cmd(OPC_WREN);
		chk(write_enable_latch, 1'b1);
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end
endmodule : sfpe_flash_seq_tb
